// ===== hw/uart_bgl_pkg.sv
// package: constants shared by the baud generator and loop-back block
// assumes: one 40 MHz clock, registers reached over classic wishbone
package uart_bgl_pkg;
  // ----------------------------------------
  // rates and widths
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned PRESCALE = 16;
  localparam logic [3:0] PRE_LAST = 4'(PRESCALE - 1);
  localparam int unsigned DIV_W = 16;
  localparam logic [15:0] DIV_ONE = 16'h0001;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // ----------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_IEN = 4'h1;
  localparam logic [3:0] IDX_ISR = 4'h2;
  localparam logic [3:0] IDX_LCTL = 4'h3;
  localparam logic [3:0] IDX_MCTL = 4'h4;
  localparam logic [3:0] IDX_LSR = 4'h5;
  localparam logic [3:0] IDX_MSR = 4'h6;
  localparam logic [3:0] IDX_SPR = 4'h7;
  localparam logic [3:0] IDX_EVT = 4'h8;
  localparam logic [3:0] IDX_MASK = 4'h9;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int unsigned LCTL_DLAB = 7;
  localparam int unsigned MCTL_LOOP = 4;
  localparam int unsigned IEN_RX = 0;
  localparam int unsigned IEN_TX = 1;
  localparam int unsigned IEN_MS = 3;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [7:0] LCTL_RST = 8'h00;
  localparam logic [7:0] MCTL_RST = 8'h00;
  localparam logic [7:0] SPR_RST = 8'hff;
  localparam logic [7:0] ISR_IDLE = 8'h01;
  localparam logic [7:0] ISR_PEND = 8'h00;
  localparam logic [2:0] EVT_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  // serial state machines, gray along the frame
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_START = 2'b01, S_DATA = 2'b11, S_STOP = 2'b10
  } ser_state_e;
endpackage : uart_bgl_pkg

// ===== hw/serial_core_if.sv
// interface: signals between core, baud generator and loop-back router
// assumes: all members live in the single clk_i domain
`timescale 1ns/1ps
interface serial_core_if;
  logic tick16;
  logic [15:0] divisor;
  logic loop;
  logic [3:0] mctl_bits;
  logic tx_core;
  logic rx_core;
  logic [3:0] modem_core;
  logic tx_pin;
  logic dtr_pin_n;
  logic rts_pin_n;
  modport gen (input divisor, output tick16);
  modport route (
    input loop, mctl_bits, tx_core,
    output rx_core, modem_core, tx_pin, dtr_pin_n, rts_pin_n
  );
  modport core (
    output divisor, loop, mctl_bits, tx_core,
    input tick16, rx_core, modem_core, tx_pin, dtr_pin_n, rts_pin_n
  );
endinterface : serial_core_if

// ===== hw/baud_gen.sv
// baud_gen: fixed divide by sixteen, then programmable divisor
// assumes: divisor is steady between host writes
`timescale 1ns/1ps
module baud_gen import uart_bgl_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  serial_core_if.gen bus
);
  // ----------------------------------------
  // prescaler and divisor counter
  // ----------------------------------------
  logic [3:0] pre_r, pre_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;

  // next values; divisor zero stops the ticks rather than wrap
  always_comb begin
    pre_nxt = pre_r + 4'h1;
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (pre_r == PRE_LAST) begin
      if (bus.divisor == 16'h0000) begin
        cnt_nxt = DIV_ONE;
      end else if (cnt_r >= bus.divisor) begin
        cnt_nxt = DIV_ONE;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + DIV_ONE;
      end
    end
  end

  // plain binary counters, no rate-dependent logic, so fast refs work
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_r <= 4'h0;
      cnt_r <= DIV_ONE;
      tick_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign bus.tick16 = tick_r;
endmodule : baud_gen

// ===== hw/loop_route.sv
// loop_route: steers serial and modem signals between pins and core
// assumes: pin inputs are synchronous to clk_i, modem pins active low
`timescale 1ns/1ps
module loop_route (
  serial_core_if.route bus,
  input wire logic rx_pin_i,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic ring_indicator_in_n_i,
  input wire logic carrier_detect_in_n_i
);
  // ----------------------------------------
  // serial path
  // ----------------------------------------
  // in loop the receiver hears its own transmitter
  assign bus.rx_core = bus.loop ? bus.tx_core : rx_pin_i;
  // line parked at mark so the far end sees idle, not test data
  assign bus.tx_pin = bus.loop ? 1'b1 : bus.tx_core;

  // ----------------------------------------
  // modem path, order {cd, ri, dsr, cts}
  // ----------------------------------------
  assign bus.modem_core = bus.loop ?
    {bus.mctl_bits[3], bus.mctl_bits[2],
     bus.mctl_bits[1], bus.mctl_bits[0]} :
    ~{carrier_detect_in_n_i, ring_indicator_in_n_i,
      dsr_n_i, cts_n_i};
  // outgoing controls parked inactive while looped
  assign bus.dtr_pin_n = bus.loop | ~bus.mctl_bits[0];
  assign bus.rts_pin_n = bus.loop | ~bus.mctl_bits[1];
endmodule : loop_route

// ===== hw/uart_bgl_top.sv
// uart_bgl_top: baud generation and loop-back diagnostics, one channel
// assumes: classic wishbone master, clk_i at 40 MHz is the reference
//
// Overview of operation
// - reference clock first divided by a fixed sixteen.
// - then divided by a programmable divisor, one to 65535.
// - divisor high and low bytes come from two host registers.
// - one generator times both transmitter and receiver.
// - works with reference clocks up to 24 MHz and beyond.
// - loop-back detaches serial pins and feeds transmitter into receiver.
// - loop-back ignores modem input pins, using modem control bits.
// - loop-back: bit 0 drives clear-to-send, bit 1 drives set-ready.
// - loop-back: bit 2 drives ring, bit 3 drives carrier detect.
// - byte written for sending returns readable as received data.
// - receive and transmit interrupts keep working in loop-back.
// - modem change interrupts in loop-back follow modem control bits.
// - every interrupt source stays gated by the enable register.
// - divisor bytes reachable only while divisor access bit 7 is set.
// - loop-back disables the serial transmit output pin.
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module uart_bgl_top import uart_bgl_pkg::*; #(
  parameter int ADR_W = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic tx_o,
  input wire logic rx_i,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic ring_indicator_in_n_i,
  input wire logic carrier_detect_in_n_i,
  output logic dtr_n_o,
  output logic rts_n_o
);
  // ----------------------------------------
  // elaboration check and sub-blocks
  // ----------------------------------------
  if (ADR_W < 6) begin : g_adr_chk
    $error("ADR_W must be at least 6");
  end

  serial_core_if sc();

  baud_gen u_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(sc.gen)
  );

  loop_route u_route (
    .bus(sc.route),
    .rx_pin_i(rx_i),
    .cts_n_i(cts_n_i),
    .dsr_n_i(dsr_n_i),
    .ring_indicator_in_n_i(ring_indicator_in_n_i),
    .carrier_detect_in_n_i(carrier_detect_in_n_i)
  );

  // ----------------------------------------
  // state declarations
  // ----------------------------------------
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [7:0] lctl_r, lctl_nxt;
  logic [7:0] ien_r, ien_nxt;
  logic [7:0] mctl_r, mctl_nxt;
  logic [7:0] spr_r, spr_nxt;
  logic [15:0] div_r, div_nxt;
  logic [2:0] evt_r, evt_nxt;
  logic [2:0] mask_r, mask_nxt;
  logic [3:0] mprev_r, mprev_nxt;
  logic [3:0] delta_r, delta_nxt;
  logic loop_r, loop_nxt;
  logic irq_r, irq_nxt;
  logic tx_pin_r, dtr_r, rts_r;
  ser_state_e txs_r, txs_nxt;
  logic [3:0] txsub_r, txsub_nxt;
  logic [2:0] txbit_r, txbit_nxt;
  logic [7:0] txsh_r, txsh_nxt;
  logic [7:0] txhold_r, txhold_nxt;
  logic txhold_full_r, txhold_full_nxt;
  logic txline_r, txline_nxt;
  logic tx_load;
  ser_state_e rxs_r, rxs_nxt;
  logic [3:0] rxsub_r, rxsub_nxt;
  logic [2:0] rxbit_r, rxbit_nxt;
  logic [7:0] rxsh_r, rxsh_nxt;
  logic [7:0] rhr_r, rhr_nxt;
  logic dr_r, dr_nxt;
  logic rx_done;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic req, wr_hit, rd_hit, dlab;
  logic txhold_wr, rhr_rd, msr_rd, temt;
  logic [3:0] idx;
  logic [3:0] mchg;
  logic [2:0] evt_set;
  logic [7:0] wbyte;

  // one-cycle answer; the ack gap keeps a held request from repeating
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign idx = wb_adr_i[5:2];
  assign wbyte = wb_dat_i[7:0];
  assign wr_hit = req & wb_we_i & wb_sel_i[0];
  assign rd_hit = req & ~wb_we_i;
  assign dlab = lctl_r[LCTL_DLAB];
  assign txhold_wr = wr_hit & (idx == IDX_DATA) & ~dlab;
  assign rhr_rd = rd_hit & (idx == IDX_DATA) & ~dlab;
  assign msr_rd = rd_hit & (idx == IDX_MSR);
  assign temt = ~txhold_full_r & (txs_r == S_IDLE);
  assign mchg = sc.modem_core ^ mprev_r;
  assign evt_set = {ien_r[IEN_MS] & (|mchg),
                    ien_r[IEN_TX] & tx_load,
                    ien_r[IEN_RX] & rx_done};

  // ----------------------------------------
  // register file and bus answer
  // ----------------------------------------
  always_comb begin
    ack_nxt = req;
    dat_nxt = 32'h0000_0000;
    lctl_nxt = lctl_r;
    ien_nxt = ien_r;
    mctl_nxt = mctl_r;
    spr_nxt = spr_r;
    div_nxt = div_r;
    mask_nxt = mask_r;
    evt_nxt = evt_r;
    loop_nxt = loop_r;
    mprev_nxt = sc.modem_core;
    // set wins over a read clear
    delta_nxt = (msr_rd ? 4'h0 : delta_r) | mchg;
    if (sc.tick16) begin
      loop_nxt = mctl_r[MCTL_LOOP];
    end
    if (rd_hit) begin
      unique case (idx)
        IDX_DATA: dat_nxt[7:0] = dlab ? div_r[7:0] : rhr_r;
        IDX_IEN: dat_nxt[7:0] = dlab ? div_r[15:8] : ien_r;
        IDX_ISR: dat_nxt[7:0] = irq_r ? ISR_PEND : ISR_IDLE;
        IDX_LCTL: dat_nxt[7:0] = lctl_r;
        IDX_MCTL: dat_nxt[7:0] = mctl_r;
        IDX_LSR: dat_nxt[7:0] = {1'b0, temt, ~txhold_full_r, 4'h0, dr_r};
        IDX_MSR: dat_nxt[7:0] = {sc.modem_core, delta_r};
        IDX_SPR: dat_nxt[7:0] = spr_r;
        IDX_EVT: dat_nxt[2:0] = evt_r;
        IDX_MASK: dat_nxt[2:0] = mask_r;
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
    // write-one clears, but a new event in the same cycle survives
    if (wr_hit && idx == IDX_EVT) begin
      evt_nxt = evt_r & ~wbyte[2:0];
    end
    evt_nxt = evt_nxt | evt_set;
    if (wr_hit) begin
      unique case (idx)
        IDX_DATA: if (dlab) div_nxt[7:0] = wbyte;
        IDX_IEN: begin
          if (dlab) begin
            div_nxt[15:8] = wbyte;
          end else begin
            ien_nxt = {4'h0, wbyte[3:0]};
          end
        end
        IDX_LCTL: lctl_nxt = wbyte;
        IDX_MCTL: mctl_nxt = {3'h0, wbyte[4:0]};
        IDX_SPR: spr_nxt = wbyte;
        IDX_MASK: mask_nxt = wbyte[2:0];
        default: ;
      endcase
    end
    irq_nxt = |(evt_nxt & mask_nxt);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      lctl_r <= LCTL_RST;
      ien_r <= IEN_RST;
      mctl_r <= MCTL_RST;
      spr_r <= SPR_RST;
      div_r <= DIV_RST;
      mask_r <= MASK_RST;
      evt_r <= EVT_RST;
      loop_r <= 1'b0;
      mprev_r <= 4'h0;
      delta_r <= 4'h0;
      irq_r <= 1'b0;
      tx_pin_r <= 1'b1;
      dtr_r <= 1'b1;
      rts_r <= 1'b1;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      lctl_r <= lctl_nxt;
      ien_r <= ien_nxt;
      mctl_r <= mctl_nxt;
      spr_r <= spr_nxt;
      div_r <= div_nxt;
      mask_r <= mask_nxt;
      evt_r <= evt_nxt;
      loop_r <= loop_nxt;
      mprev_r <= mprev_nxt;
      delta_r <= delta_nxt;
      irq_r <= irq_nxt;
      tx_pin_r <= sc.tx_pin;
      dtr_r <= sc.dtr_pin_n;
      rts_r <= sc.rts_pin_n;
    end
  end

  // ----------------------------------------
  // transmitter, fixed 8 data bits, one stop bit
  // ----------------------------------------
  always_comb begin
    txs_nxt = txs_r;
    txsub_nxt = txsub_r;
    txbit_nxt = txbit_r;
    txsh_nxt = txsh_r;
    txhold_nxt = txhold_r;
    txhold_full_nxt = txhold_full_r;
    txline_nxt = txline_r;
    tx_load = 1'b0;
    if (sc.tick16) begin
      txsub_nxt = txsub_r + 4'h1;
      unique case (txs_r)
        S_IDLE: begin
          txsub_nxt = 4'h0;
          if (txhold_full_r) begin
            txsh_nxt = txhold_r;
            txhold_full_nxt = 1'b0;
            tx_load = 1'b1;
            txs_nxt = S_START;
            txline_nxt = 1'b0;
          end
        end
        S_START: begin
          if (txsub_r == SUB_LAST) begin
            txs_nxt = S_DATA;
            txbit_nxt = 3'h0;
            txline_nxt = txsh_r[0];
          end
        end
        S_DATA: begin
          if (txsub_r == SUB_LAST) begin
            txsh_nxt = {1'b0, txsh_r[7:1]};
            txbit_nxt = txbit_r + 3'h1;
            txline_nxt = txsh_r[1];
            if (txbit_r == BIT_LAST) begin
              txs_nxt = S_STOP;
              txline_nxt = 1'b1;
            end
          end
        end
        S_STOP: begin
          if (txsub_r == SUB_LAST) begin
            txs_nxt = S_IDLE;
          end
        end
      endcase
    end
    // a write while still full overwrites the waiting byte
    if (txhold_wr) begin
      txhold_nxt = wbyte;
      txhold_full_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txs_r <= S_IDLE;
      txsub_r <= 4'h0;
      txbit_r <= 3'h0;
      txsh_r <= 8'h00;
      txhold_r <= 8'h00;
      txhold_full_r <= 1'b0;
      txline_r <= 1'b1;
    end else begin
      txs_r <= txs_nxt;
      txsub_r <= txsub_nxt;
      txbit_r <= txbit_nxt;
      txsh_r <= txsh_nxt;
      txhold_r <= txhold_nxt;
      txhold_full_r <= txhold_full_nxt;
      txline_r <= txline_nxt;
    end
  end

  // ----------------------------------------
  // receiver, samples mid-bit on the shared ticks
  // ----------------------------------------
  always_comb begin
    rxs_nxt = rxs_r;
    rxsub_nxt = rxsub_r;
    rxbit_nxt = rxbit_r;
    rxsh_nxt = rxsh_r;
    rhr_nxt = rhr_r;
    rx_done = 1'b0;
    if (sc.tick16) begin
      rxsub_nxt = rxsub_r + 4'h1;
      unique case (rxs_r)
        S_IDLE: begin
          rxsub_nxt = 4'h0;
          if (!sc.rx_core) rxs_nxt = S_START;
        end
        S_START: begin
          if (rxsub_r == SUB_MID) begin
            rxsub_nxt = 4'h0;
            rxbit_nxt = 3'h0;
            // a glitch shorter than half a bit is not a start
            rxs_nxt = sc.rx_core ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (rxsub_r == SUB_LAST) begin
            rxsh_nxt = {sc.rx_core, rxsh_r[7:1]};
            rxbit_nxt = rxbit_r + 3'h1;
            if (rxbit_r == BIT_LAST) rxs_nxt = S_STOP;
          end
        end
        S_STOP: begin
          if (rxsub_r == SUB_LAST) begin
            rhr_nxt = rxsh_r;
            rx_done = 1'b1;
            rxs_nxt = S_IDLE;
          end
        end
      endcase
    end
    dr_nxt = (dr_r & ~rhr_rd) | rx_done;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxs_r <= S_IDLE;
      rxsub_r <= 4'h0;
      rxbit_r <= 3'h0;
      rxsh_r <= 8'h00;
      rhr_r <= 8'h00;
      dr_r <= 1'b0;
    end else begin
      rxs_r <= rxs_nxt;
      rxsub_r <= rxsub_nxt;
      rxbit_r <= rxbit_nxt;
      rxsh_r <= rxsh_nxt;
      rhr_r <= rhr_nxt;
      dr_r <= dr_nxt;
    end
  end

  // ----------------------------------------
  // interface and outputs
  // ----------------------------------------
  assign sc.divisor = div_r;
  assign sc.loop = loop_r;
  assign sc.mctl_bits = mctl_r[3:0];
  assign sc.tx_core = txline_r;
  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign irq_o = irq_r;
  assign tx_o = tx_pin_r;
  assign dtr_n_o = dtr_r;
  assign rts_n_o = rts_r;
endmodule : uart_bgl_top

// ===== verif/line_partner.sv
// line_partner: far-side serial line and modem for the block
// assumes: bench clock, modem states given active high by the bench
`timescale 1ns/1ps
module line_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tx_i,
  input wire logic noisy_i,
  input wire logic [3:0] st_i,
  output logic rx_o = 1'b1,
  output logic [3:0] modem_n_o = 4'hf
);
  // ----------------------------------------
  // line echo and modem pins
  // ----------------------------------------
  // noisy line toggles every cycle, so a leak into the receiver shows
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_o <= 1'b1;
    end else begin
      rx_o <= noisy_i ? ~rx_o : tx_i;
    end
    modem_n_o <= ~st_i; // pins are active low
  end
endmodule : line_partner

// ===== verif/uart_bgl_properties.sv
// checker: bus, reset, loop-back pin and interrupt mask relations
// assumes: bound into uart_bgl_top, one clock, sync active-high reset
`timescale 1ns/1ps
module uart_bgl_properties import uart_bgl_pkg::*; #(
  parameter int ADR_W = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic tx_o,
  input wire logic dtr_n_o,
  input wire logic rts_n_o
);
  // ----------------------------------------
  // shadow of the modem control byte
  // ----------------------------------------
  // age saturates well past one tick16 for the divisors in use
  localparam int SETTLE = 1100;
  logic [7:0] mctl_r, mctl_nxt;
  logic [10:0] age_r, age_nxt;
  logic mctl_wr;
  assign mctl_wr = wb_ack_o && wb_we_i && wb_sel_i[0] &&
    wb_adr_i[5:2] == IDX_MCTL;
  always_comb begin
    mctl_nxt = mctl_r;
    age_nxt = age_r;
    if (rst_i) begin
      mctl_nxt = MCTL_RST;
      age_nxt = 11'h0;
    end else if (mctl_wr) begin
      mctl_nxt = wb_dat_i[7:0];
      age_nxt = 11'h0;
    end else if (age_r != 11'(SETTLE)) begin
      age_nxt = age_r + 11'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    mctl_r <= mctl_nxt;
    age_r <= age_nxt;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ANSWER:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged one cycle later");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE:
    assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  AST_DAT_IDLE:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  AST_UNMAPPED_RD:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i[5:2] > IDX_MASK
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  AST_AFTER_RESET:
    assert property ($fell(rst_i) |-> tx_o && dtr_n_o && rts_n_o &&
      !irq_o && !wb_ack_o) else $error("outputs not idle after reset");
  AST_LOOP_PINS:
    assert property (mctl_r[MCTL_LOOP] && age_r == 11'(SETTLE)
      |-> tx_o && dtr_n_o && rts_n_o) else $error("pins driven in loop");
  AST_MODEM_OUT:
    assert property (!mctl_r[MCTL_LOOP] && age_r == 11'(SETTLE)
      |-> dtr_n_o == !mctl_r[0] && rts_n_o == !mctl_r[1])
    else $error("modem outputs do not follow control byte");
  AST_MASK_ZERO:
    assert property (wb_ack_o && wb_we_i && wb_sel_i[0] &&
      wb_adr_i[5:2] == IDX_MASK && wb_dat_i[2:0] == 3'h0 |=> ##1 !irq_o)
    else $error("interrupt high with all sources masked");
endmodule : uart_bgl_properties
bind uart_bgl_top uart_bgl_properties #(.ADR_W(ADR_W)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o), .tx_o(tx_o), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o)
);

// ===== verif/uart_baud_gen_loopback_test.sv
// testbench: registers, frame timing, loop-back and interrupts
// assumes: line_partner on the serial side, checker bound separately
`timescale 1ns/1ps
module uart_baud_gen_loopback_test;
  import uart_bgl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, noisy = 1'b0;
  logic [5:0] adr = 6'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0] st = 4'h0, m;
  logic [31:0] wb_dat_o, lfsr = 32'h16e0;
  logic wb_ack_o, irq_o, tx_o, rx_i, dtr_n_o, rts_n_o;
  logic [3:0] modem_n;
  logic [15:0] expq[$];
  logic [15:0] e;
  int n_fail = 0, checks = 0, n, i;
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  uart_bgl_top #(.ADR_W(6)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .tx_o(tx_o), .rx_i(rx_i),
    .cts_n_i(modem_n[0]), .dsr_n_i(modem_n[1]),
    .ring_indicator_in_n_i(modem_n[2]),
    .carrier_detect_in_n_i(modem_n[3]), .dtr_n_o(dtr_n_o),
    .rts_n_o(rts_n_o));
  line_partner u_line (.clk_i(clk_i), .rst_i(rst_i), .tx_i(tx_o),
    .noisy_i(noisy), .st_i(st), .rx_o(rx_i), .modem_n_o(modem_n));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  task report_and_stop;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  // one classic cycle; a read notes {mask, expected} for the monitor
  task wb(input logic w, input logic [3:0] idx, input logic [7:0] d,
          input logic [15:0] mx);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    if (!w) expq.push_back(mx);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
  endtask : wb
  task wait_irq(input int lim);
    n = 0;
    while (irq_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(n < lim), 32'h1);
  endtask : wait_irq
  // read data is taken at the ack edge, before the design moves on
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && we === 1'b0 && expq.size() > 0) begin
      e = expq.pop_front();
      check(wb_dat_o & {24'h0, e[15:8]}, {24'h0, e[7:0]});
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(32'({tx_o, dtr_n_o, rts_n_o, irq_o}), 32'he);
    wb(0, IDX_LCTL, 8'h0, {8'hff, LCTL_RST});
    wb(0, IDX_MCTL, 8'h0, {8'hff, MCTL_RST});
    wb(0, IDX_SPR, 8'h0, {8'hff, SPR_RST});
    wb(0, IDX_ISR, 8'h0, {8'hff, ISR_IDLE});
    wb(0, 4'ha, 8'h0, 16'hff00);
    wb(1, IDX_LCTL, 8'h80, 16'h0);
    wb(0, IDX_DATA, 8'h0, {8'hff, DIV_RST[7:0]});
    wb(1, IDX_DATA, 8'h02, 16'h0);
    wb(1, IDX_IEN, 8'h00, 16'h0);
    wb(0, IDX_DATA, 8'h0, 16'hff02);
    wb(1, IDX_LCTL, 8'h00, 16'h0);
    wb(0, IDX_IEN, 8'h0, {8'hff, IEN_RST});
    // normal frame at divisor 2, echoed back by the line
    wb(1, IDX_IEN, 8'h0b, 16'h0);
    wb(1, IDX_MASK, 8'h01, 16'h0);
    wb(1, IDX_DATA, 8'hfe, 16'h0);
    n = 0;
    while (tx_o !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (tx_o === 1'b0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(n), 32'(2 * 16 * PRESCALE * 2));
    wait_irq(6000);
    wb(0, IDX_DATA, 8'h0, 16'hfffe);
    wb(1, IDX_EVT, 8'h07, 16'h0);
    wb(1, IDX_MASK, 8'h00, 16'h0);
    wb(1, IDX_LCTL, 8'h80, 16'h0);
    wb(1, IDX_DATA, 8'h01, 16'h0);
    wb(1, IDX_LCTL, 8'h00, 16'h0);
    // loop-back with opposite modem pins, then a noisy line
    for (i = 0; i < 2; i++) begin
      m = i ? 4'ha : 4'h5;
      st <= ~m;
      wb(1, IDX_MCTL, {4'h1, m}, 16'h0);
      repeat (40) @(posedge clk_i);
      // noise only once looped, else the receiver frames it
      noisy <= 1'b1;
      check(32'({tx_o, dtr_n_o, rts_n_o}), 32'h7);
      wb(0, IDX_MSR, 8'h0, {8'hf0, m, 4'h0});
    end
    check(32'(irq_o), 32'h0);
    wb(1, IDX_MASK, 8'h04, 16'h0);
    wait_irq(10);
    wb(1, IDX_EVT, 8'h07, 16'h0);
    wb(1, IDX_IEN, 8'h03, 16'h0);
    wb(1, IDX_MCTL, 8'h1b, 16'h0);
    repeat (40) @(posedge clk_i);
    check(32'(irq_o), 32'h0);
    wb(1, IDX_IEN, 8'h0b, 16'h0);
    wb(1, IDX_MCTL, 8'h1a, 16'h0);
    wait_irq(100);
    wb(1, IDX_EVT, 8'h07, 16'h0);
    wb(1, IDX_MASK, 8'h01, 16'h0);
    for (i = 0; i < 3; i++) begin
      lfsr = next_rand(lfsr);
      wb(1, IDX_DATA, lfsr[7:0], 16'h0);
      wait_irq(4000);
      wb(0, IDX_DATA, 8'h0, {8'hff, lfsr[7:0]});
      wb(1, IDX_EVT, 8'h07, 16'h0);
    end
    // leaving loop-back gives the pins back
    noisy <= 1'b0;
    wb(1, IDX_MCTL, 8'h03, 16'h0);
    repeat (40) @(posedge clk_i);
    check(32'({dtr_n_o, rts_n_o}), 32'h0);
    report_and_stop();
  end
endmodule : uart_baud_gen_loopback_test
